// ==== src/twcs_defs.svh ====
// constants for the two-wire control slave
`ifndef TWCS_DEFS_SVH
`define TWCS_DEFS_SVH
`define TWCS_DEV_ADDR   7'h1A
`define TWCS_REG_AW     7
`define TWCS_REG_DW     9
`define TWCS_REG_LAST   7'h7F
`define TWCS_REG_FIRST  7'h00
`define TWCS_RST_REG    9'h000
`define TWCS_BIT_LAST   3'h7
`endif

// ==== src/twcs_pkg.sv ====
// types for the two-wire control slave
`default_nettype none
package twcs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100,
    ST_WAIT = 3'b101
  } twcs_state_e;
  typedef enum logic [1:0] {
    PH_DEV  = 2'b00,
    PH_CTRL = 2'b01,
    PH_DATA = 2'b10
  } twcs_phase_e;
endpackage
`default_nettype wire

// ==== src/twcs_regfile.sv ====
// control register storage with registered read data
`include "twcs_defs.svh"
`default_nettype none
module twcs_regfile (
  input  wire logic                        clk_i,
  input  wire logic                        we_i,
  input  wire logic [`TWCS_REG_AW-1:0]     waddr_i,
  input  wire logic [`TWCS_REG_DW-1:0]     wdata_i,
  input  wire logic [`TWCS_REG_AW-1:0]     raddr_i,
  output logic      [`TWCS_REG_DW-1:0]     rdata_o
);
  logic [`TWCS_REG_DW-1:0] mem_ff [0:(1<<`TWCS_REG_AW)-1];
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_ff[raddr_i];
  end
endmodule
`default_nettype wire

// ==== src/twcs_top.sv ====
// two-wire control slave: start/stop, address match, register access
//
// Overview of operation
// - detect start: data falls, clock high
// - detect stop: data rises, clock high
// - stop after write returns to idle
// - bytes shift most significant bit first
// - transmitter releases data after eight bits
// - receiver pulls data low on ninth
// - answer only bus address 0011010
// - address bit zero: one read, zero write
// - acknowledge low on match, else high
// - acknowledge address, control, data bytes
// - acknowledge three bytes of read setup
// - keep sending while master acknowledges
// - pointer advances, wraps 7Fh to 00h
`include "twcs_defs.svh"
`default_nettype none
module twcs_top (
  input  wire logic                    clk_i,
  input  wire logic                    reset_n_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic                         sda_o,
  output logic                         sda_oe_o,
  output logic                         busy_o,
  output logic                         wr_strobe_o,
  output logic [`TWCS_REG_AW-1:0]      wr_addr_o,
  output logic [`TWCS_REG_DW-1:0]      wr_data_o
);
  logic rst_meta_ff;
  logic rst_n_ff;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff    <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff    <= rst_meta_ff;
    end
  end

  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic       scl_ff;
  logic       sda_ff;
  logic       nxt_scl;
  logic       nxt_sda;
  always_comb begin
    nxt_scl = scl_ff;
    nxt_sda = sda_ff;
    if (scl_sync_ff[1] == scl_sync_ff[2]) begin
      nxt_scl = scl_sync_ff[2];
    end
    if (sda_sync_ff[1] == sda_sync_ff[2]) begin
      nxt_sda = sda_sync_ff[2];
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      scl_sync_ff <= 3'h7;
      sda_sync_ff <= 3'h7;
      scl_ff      <= 1'b1;
      sda_ff      <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
      sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
      scl_ff      <= nxt_scl;
      sda_ff      <= nxt_sda;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_rise  = nxt_scl & ~scl_ff;
  assign scl_fall  = ~nxt_scl & scl_ff;
  assign start_det = scl_ff & nxt_scl & sda_ff & ~nxt_sda;
  assign stop_det  = scl_ff & nxt_scl & ~sda_ff & nxt_sda;

  twcs_pkg::twcs_state_e   state_ff;
  twcs_pkg::twcs_state_e   nxt_state;
  twcs_pkg::twcs_phase_e   phase_ff;
  twcs_pkg::twcs_phase_e   nxt_phase;
  logic [7:0]              shift_ff;
  logic [7:0]              nxt_shift;
  logic [2:0]              cnt_ff;
  logic [2:0]              nxt_cnt;
  logic                    rd_ff;
  logic                    nxt_rd;
  logic [`TWCS_REG_AW-1:0] ptr_ff;
  logic [`TWCS_REG_AW-1:0] nxt_ptr;
  logic                    msb_ff;
  logic                    nxt_msb;
  logic                    sda_out_ff;
  logic                    nxt_sda_out;
  logic                    oe_ff;
  logic                    nxt_oe;
  logic                    wr_ff;
  logic                    nxt_wr;
  logic [`TWCS_REG_DW-1:0] wdata_ff;
  logic [`TWCS_REG_DW-1:0] nxt_wdata;
  logic [`TWCS_REG_DW-1:0] rdata;
  logic                    full_ff;
  logic                    nxt_full;
  logic                    busy_ff;
  logic                    nxt_busy;

  always_comb begin
    nxt_state   = state_ff;
    nxt_phase   = phase_ff;
    nxt_shift   = shift_ff;
    nxt_cnt     = cnt_ff;
    nxt_rd      = rd_ff;
    nxt_ptr     = ptr_ff;
    nxt_msb     = msb_ff;
    nxt_sda_out = sda_out_ff;
    nxt_oe      = oe_ff;
    nxt_wr      = 1'b0;
    nxt_wdata   = wdata_ff;
    nxt_full    = full_ff;
    if (start_det) begin
      // repeated start re-enters address phase, pointer kept
      nxt_state = twcs_pkg::ST_RECV;
      nxt_phase = twcs_pkg::PH_DEV;
      nxt_cnt   = 3'h0;
      nxt_full  = 1'b0;
      nxt_oe    = 1'b0;
    end else if (stop_det) begin
      nxt_state = twcs_pkg::ST_IDLE;
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        twcs_pkg::ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        twcs_pkg::ST_RECV: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_ff};
            nxt_cnt   = cnt_ff + 3'h1;
            nxt_full  = (cnt_ff == `TWCS_BIT_LAST);
          end else if (scl_fall && full_ff) begin
            // bits are counted on rises, so the clock fall that
            // closes a start is never taken for a data bit
            nxt_full  = 1'b0;
            nxt_state = twcs_pkg::ST_ACK;
            case (phase_ff)
              twcs_pkg::PH_DEV: begin
                if (shift_ff[7:1] == `TWCS_DEV_ADDR) begin
                  nxt_rd = shift_ff[0];
                  nxt_sda_out = 1'b0;
                  nxt_oe      = 1'b1;
                end else begin
                  nxt_state = twcs_pkg::ST_WAIT;
                end
              end
              twcs_pkg::PH_CTRL: begin
                nxt_ptr     = shift_ff[7:1];
                nxt_msb     = shift_ff[0];
                nxt_sda_out = 1'b0;
                nxt_oe      = 1'b1;
              end
              default: begin
                nxt_wdata   = {msb_ff, shift_ff};
                nxt_wr      = 1'b1;
                nxt_sda_out = 1'b0;
                nxt_oe      = 1'b1;
              end
            endcase
          end
        end
        twcs_pkg::ST_ACK: begin
          if (scl_fall) begin
            nxt_oe = 1'b0;
            if (phase_ff == twcs_pkg::PH_DEV && rd_ff) begin
              nxt_phase   = twcs_pkg::PH_DATA;
              nxt_state   = twcs_pkg::ST_SEND;
              nxt_shift   = rdata[7:0];
              nxt_sda_out = rdata[7];
              nxt_oe      = 1'b1;
            end else if (phase_ff == twcs_pkg::PH_DEV) begin
              nxt_phase = twcs_pkg::PH_CTRL;
              nxt_state = twcs_pkg::ST_RECV;
            end else if (phase_ff == twcs_pkg::PH_CTRL) begin
              nxt_phase = twcs_pkg::PH_DATA;
              nxt_state = twcs_pkg::ST_RECV;
            end else begin
              // further bytes continue the sequence
              nxt_ptr   = ptr_ff + 7'h01;
              nxt_state = twcs_pkg::ST_RECV;
            end
          end
        end
        twcs_pkg::ST_SEND: begin
          if (scl_fall && cnt_ff == `TWCS_BIT_LAST) begin
            nxt_oe    = 1'b0;
            nxt_cnt   = 3'h0;
            nxt_state = twcs_pkg::ST_MACK;
          end else if (scl_fall) begin
            nxt_shift   = {shift_ff[6:0], 1'b0};
            nxt_sda_out = shift_ff[6];
            nxt_cnt     = cnt_ff + 3'h1;
          end
        end
        twcs_pkg::ST_MACK: begin
          if (scl_rise) begin
            if (!sda_ff) begin
              nxt_ptr = (ptr_ff == `TWCS_REG_LAST) ?
                        `TWCS_REG_FIRST : ptr_ff + 7'h01;
            end else begin
              nxt_state = twcs_pkg::ST_WAIT;
            end
          end else if (scl_fall) begin
            nxt_state   = twcs_pkg::ST_SEND;
            nxt_shift   = rdata[7:0];
            nxt_sda_out = rdata[7];
            nxt_oe      = 1'b1;
          end
        end
        twcs_pkg::ST_WAIT: begin
          nxt_oe = 1'b0;
        end
        default: begin
          nxt_state = twcs_pkg::ST_IDLE;
          nxt_oe    = 1'b0;
        end
      endcase
    end
    // registered so the port carries no decode glitches
    nxt_busy = (nxt_state != twcs_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff   <= twcs_pkg::ST_IDLE;
      phase_ff   <= twcs_pkg::PH_DEV;
      shift_ff   <= 8'h00;
      cnt_ff     <= 3'h0;
      rd_ff      <= 1'b0;
      ptr_ff     <= `TWCS_REG_FIRST;
      msb_ff     <= 1'b0;
      sda_out_ff <= 1'b1;
      oe_ff      <= 1'b0;
      wr_ff      <= 1'b0;
      wdata_ff   <= `TWCS_RST_REG;
      full_ff    <= 1'b0;
      busy_ff    <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      phase_ff   <= nxt_phase;
      shift_ff   <= nxt_shift;
      cnt_ff     <= nxt_cnt;
      rd_ff      <= nxt_rd;
      ptr_ff     <= nxt_ptr;
      msb_ff     <= nxt_msb;
      sda_out_ff <= nxt_sda_out;
      oe_ff      <= nxt_oe;
      wr_ff      <= nxt_wr;
      wdata_ff   <= nxt_wdata;
      full_ff    <= nxt_full;
      busy_ff    <= nxt_busy;
    end
  end

  // read data is registered, so the pointer must settle a few
  // clocks before the scl fall that loads the shifter
  twcs_regfile u_regfile (
    .clk_i   (clk_i),
    .we_i    (wr_ff),
    .waddr_i (ptr_ff),
    .wdata_i (wdata_ff),
    .raddr_i (ptr_ff),
    .rdata_o (rdata)
  );

  assign sda_o       = sda_out_ff;
  assign sda_oe_o    = oe_ff;
  assign busy_o      = busy_ff;
  assign wr_strobe_o = wr_ff;
  assign wr_addr_o   = ptr_ff;
  assign wr_data_o   = wdata_ff;
endmodule
`default_nettype wire

// ==== sim/twcs_master.sv ====
// two-wire bus master model: drives the clock and open-drain data
`default_nettype none
module twcs_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // clock stands high and data is released between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    w(4);
    sda_low_o = 1'b0;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_low_o = 1'b1;
    w(8);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    w(4);
    sda_low_o = 1'b1;
    w(4);
    scl_o = 1'b1;
    w(8);
    sda_low_o = 1'b0;
    w(8);
  endtask
  // data moves mid-low so no false start or stop
  task automatic bit_x(input logic b, output logic s);
    w(4);
    sda_low_o = !b;
    w(4);
    scl_o = 1'b1;
    w(8);
    s = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/twcs_top_chk.sv ====
// port assertions for the two-wire control slave
`default_nettype none
module twcs_top_chk (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       busy_o,
  input wire logic       wr_strobe_o,
  input wire logic [6:0] wr_addr_o,
  input wire logic [8:0] wr_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_start_busy: assert property (
    $fell(sda_i) && scl_i && $past(scl_i) |-> ##[1:10] busy_o)
    else $error("start not detected");
  a_busy_cause: assert property (
    $rose(busy_o) |-> scl_i && !sda_i)
    else $error("busy rose without start");
  a_stop_idle: assert property (
    $rose(sda_i) && scl_i && $past(scl_i) |-> ##[1:10] !busy_o)
    else $error("stop did not return to idle");
  // the device may only move the data line while the clock is low
  a_sda_quiet: assert property (
    $changed(sda_oe_o) || sda_oe_o && $changed(sda_o) |-> !scl_i)
    else $error("data line moved with clock high");
  a_drive_holds: assert property (
    $rose(sda_oe_o) |=> sda_oe_o [*4])
    else $error("drive dropped too early");
  a_idle_quiet: assert property (
    sda_oe_o |-> busy_o)
    else $error("drive while idle");
  a_strobe_pulse: assert property (
    wr_strobe_o |=> !wr_strobe_o)
    else $error("write strobe longer than one cycle");
  a_strobe_low: assert property (
    wr_strobe_o |-> busy_o && !scl_i)
    else $error("write strobe outside a clock low phase");
  a_data_cause: assert property (
    $changed(wr_data_o) |-> wr_strobe_o)
    else $error("write data changed without strobe");
endmodule
bind twcs_top twcs_top_chk u_twcs_top_chk (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o),
  .wr_strobe_o(wr_strobe_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o)
);
`default_nettype wire

// ==== sim/tb.sv ====
// testbench for the two-wire control slave
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i;
  logic        reset_n_i;
  logic        scl;
  logic        sda;
  logic        m_low;
  logic        sda_o;
  logic        sda_oe;
  logic        busy;
  logic        wr_stb;
  logic [6:0]  wr_addr;
  logic [8:0]  wr_data;
  logic [15:0] last_wr;
  logic [15:0] n_wr = 16'h0000;
  int          fail_count = 0;
  int          check_count = 0;
  // open-drain line with pull-up
  assign sda = !(m_low || (sda_oe === 1'b1 && sda_o === 1'b0));
  twcs_top u_twcs_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .busy_o(busy), .wr_strobe_o(wr_stb), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data));
  twcs_master u_twcs_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl),
    .sda_low_o(m_low));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (wr_stb === 1'b1) begin
      n_wr <= n_wr + 16'h0001;
      last_wr <= {wr_addr, wr_data};
    end
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr_b(input logic [7:0] d, input logic ack_lvl);
    logic [7:0] q;
    logic       a;
    u_twcs_master.xfer(d, q);
    u_twcs_master.bit_x(1'b1, a);
    chk(a, ack_lvl);
  endtask
  task automatic rd_b(input logic [7:0] e, input logic ack);
    logic [7:0] q;
    logic       a;
    u_twcs_master.xfer(8'hFF, q);
    u_twcs_master.bit_x(!ack, a);
    chk(q, e);
  endtask
  task automatic stop_idle();
    u_twcs_master.stop();
    repeat (12) @(posedge clk_i);
    #1;
    chk(busy, 1'b0);
  endtask
  task automatic t_write();
    u_twcs_master.start();
    wr_b(8'h34, 1'b0);
    wr_b(8'hFF, 1'b0);
    wr_b(8'hA5, 1'b0);
    chk(last_wr, {7'h7F, 9'h1A5});
    wr_b(8'hC3, 1'b0);
    stop_idle();
    chk(n_wr, 16'h0002);
    chk(last_wr, {7'h00, 9'h1C3});
  endtask
  task automatic t_read();
    u_twcs_master.start();
    wr_b(8'h34, 1'b0);
    wr_b(8'hFE, 1'b0);
    u_twcs_master.start();
    wr_b(8'h35, 1'b0);
    rd_b(8'hA5, 1'b1);
    rd_b(8'hC3, 1'b0);
    stop_idle();
  endtask
  task automatic t_bad_addr();
    u_twcs_master.start();
    wr_b(8'h36, 1'b1);
    stop_idle();
    u_twcs_master.start();
    wr_b(8'hB4, 1'b1);
    stop_idle();
    chk(n_wr, 16'h0002);
  endtask
  initial begin
    reset_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    chk({busy, sda_oe, wr_stb}, 16'h0000);
    reset_n_i = 1'b1;
    repeat (10) @(posedge clk_i);
    #1;
    t_write();
    t_read();
    t_bad_addr();
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
